// File: hw/ivs_map.vh
`ifndef IVS_MAP_VH
`define IVS_MAP_VH
// register byte offsets on apb
`define IVS_OFF_EN_FIRST  12'h000
`define IVS_OFF_EN_SECOND 12'h004
`define IVS_OFF_NMICTL    12'h008
`define IVS_OFF_MASK_FLAG 12'h00C
`define IVS_OFF_NMI_FLAG  12'h010
`define IVS_OFF_IRQ_MASK  12'h014
`define IVS_OFF_VECTOR    12'h018
`define IVS_OFF_IRQ_STAT  12'h01C
// reset values
`define IVS_EN_FIRST_RST  8'h00
`define IVS_EN_SECOND_RST 8'h00
`define IVS_NMICTL_RST    8'h00
// first irq-enable register bit positions
`define IVS_B_EXT0        0
`define IVS_B_TMR0        1
`define IVS_B_EXT1        2
`define IVS_B_TMR1        3
`define IVS_B_SER         4
`define IVS_B_T2GRP       5
// second irq-enable register bit position
`define IVS_B_ADC         0
// nonmaskable control bit positions
`define IVS_B_NMI_WDT     0
`define IVS_B_NMI_PLL     1
`define IVS_B_NMI_FLASH   2
`define IVS_B_NMI_VCORE   3
`define IVS_B_NMI_VPAD    4
`define IVS_B_NMI_ECC     5
// maskable flag register layout: bits 0..4 vectors 0..4, 5..7 timer-2 group, 8 adc
`define IVS_F_TMR2        5
`define IVS_F_FDIV        6
`define IVS_F_LIN         7
`define IVS_F_ADC         8
// vector addresses
`define IVS_VEC_NMI       16'h0073
`define IVS_VEC_BASE      16'h0003
`define IVS_VEC_STEP      16'h0008
// sticky status bits
`define IVS_S_ACCEPT      0
`define IVS_S_NMI         1
`endif

// File: hw/ivs_flags.v
`timescale 1ns/100ps
`default_nettype none
// sticky request flags: set by a source pulse, cleared by writing one; set wins
module ivs_flags #(
    parameter W = 9
) (
    input  wire         sys_clk,
    input  wire         rstn,
    input  wire [W-1:0] set_in,
    input  wire [W-1:0] clr_in,
    output wire [W-1:0] flag_out
);
    reg [W-1:0] flag_r;
    wire [W-1:0] flag_nxt;

    assign flag_nxt = set_in | (flag_r & ~clr_in);
    assign flag_out = flag_r;

    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            flag_r <= {W{1'b0}};
        end else begin
            flag_r <= flag_nxt;
        end
    end
endmodule
`default_nettype wire

// File: hw/ivs_sync.v
`timescale 1ns/100ps
`default_nettype none
// two-flop synchroniser for pin-level requests
module ivs_sync #(
    parameter W = 2
) (
    input  wire         sys_clk,
    input  wire         rstn,
    input  wire [W-1:0] async_in,
    output wire [W-1:0] sync_out
);
    reg [W-1:0] meta_r;
    reg [W-1:0] sync_r;

    assign sync_out = sync_r;

    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            meta_r <= {W{1'b0}};
            sync_r <= {W{1'b0}};
        end else begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end
endmodule
`default_nettype wire

// File: hw/ivs_ctrl.v
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "ivs_map.vh"
module ivs_ctrl (
    input  wire        sys_clk,
    input  wire        rstn,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    // external interrupt pins (asynchronous)
    input  wire        ext_irq0_pin,
    input  wire        ext_irq1_pin,
    // on-chip request pulses (sys_clk domain)
    input  wire        timer0_req,
    input  wire        timer1_req,
    input  wire        serial_req,
    input  wire        timer2_req,
    input  wire        fdiv_ovf_req,
    input  wire        lin_req,
    input  wire        adc_req,
    input  wire [5:0]  nmi_src_req,
    // core side
    output wire        core_irq_req,
    output wire        core_nmi_req,
    output reg  [15:0] core_vector,
    input  wire        core_ack,
    output wire        irq
);
    reg  [7:0]  irq_enable_reg_first_r;
    reg  [7:0]  irq_enable_reg_second_r;
    reg  [7:0]  nonmaskable_control_reg_r;
    reg  [1:0]  stat_r;
    reg  [1:0]  irq_mask_r;
    reg  [1:0]  ext_prev_r;
    reg         core_ack_d_r;

    wire [1:0]  ext_sync;
    wire [1:0]  ext_rise;
    wire [8:0]  mflag;
    wire [5:0]  nflag;
    wire [8:0]  mset;
    wire [8:0]  mclr;
    wire [5:0]  nclr;
    wire [6:0]  vec_pend;
    wire [5:0]  nmi_pend;
    wire        wr_en;
    wire        rd_setup;
    wire        ack_edge;
    wire        addr_ok;
    wire [1:0]  stat_set;
    wire        hit_en_first;
    wire        hit_en_second;
    wire        hit_nmi_ctl;
    wire        hit_mflag;
    wire        hit_nflag;
    wire        hit_irq_mask;
    wire        hit_irq_stat;
    wire        hit_vector;
    reg  [7:0]  en_first_nxt;
    reg  [7:0]  en_second_nxt;
    reg  [7:0]  nmi_ctl_nxt;
    reg  [1:0]  irq_mask_nxt;
    reg  [1:0]  stat_nxt;
    reg  [15:0] vector_nxt;
    reg  [31:0] rd_nxt;

    wire        ext_irq0_enable         = irq_enable_reg_first_r[`IVS_B_EXT0];
    wire        timer0_irq_enable       = irq_enable_reg_first_r[`IVS_B_TMR0];
    wire        ext_irq1_enable         = irq_enable_reg_first_r[`IVS_B_EXT1];
    wire        timer1_irq_enable       = irq_enable_reg_first_r[`IVS_B_TMR1];
    wire        serial_irq_enable       = irq_enable_reg_first_r[`IVS_B_SER];
    wire        timer2_group_irq_enable = irq_enable_reg_first_r[`IVS_B_T2GRP];
    wire        converter_irq_enable    = irq_enable_reg_second_r[`IVS_B_ADC];

    // fixed vector of a maskable vector index: base plus eight per step
    function [15:0] vec_addr;
        input [2:0] idx;
        begin
            vec_addr = `IVS_VEC_BASE + ({13'h0000, idx} << 3);
        end
    endfunction

    function [2:0] first_set;
        input [6:0] v;
        integer i;
        begin
            first_set = 3'h0;
            for (i = 6; i >= 0; i = i - 1) begin
                if (v[i]) begin
                    first_set = i[2:0];
                end
            end
        end
    endfunction

    // true when the bus address selects the given register offset
    function is_reg;
        input [11:0] addr;
        input [11:0] off;
        begin
            is_reg = (addr == off);
        end
    endfunction

    // pins are asynchronous: two flops before the edge detector reads them
    ivs_sync #(
        .W(2)
    ) u_sync (
        .sys_clk  (sys_clk),
        .rstn     (rstn),
        .async_in ({ext_irq1_pin, ext_irq0_pin}),
        .sync_out (ext_sync)
    );

    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ext_prev_r <= 2'h0;
        end else begin
            ext_prev_r <= ext_sync;
        end
    end

    assign ext_rise = ext_sync & ~ext_prev_r;

    assign wr_en = psel & penable & pwrite;
    assign pready = 1'b1;

    // register decode, shared by the write, clear and error paths
    assign hit_en_first  = is_reg(paddr, `IVS_OFF_EN_FIRST);
    assign hit_en_second = is_reg(paddr, `IVS_OFF_EN_SECOND);
    assign hit_nmi_ctl   = is_reg(paddr, `IVS_OFF_NMICTL);
    assign hit_mflag     = is_reg(paddr, `IVS_OFF_MASK_FLAG);
    assign hit_nflag     = is_reg(paddr, `IVS_OFF_NMI_FLAG);
    assign hit_irq_mask  = is_reg(paddr, `IVS_OFF_IRQ_MASK);
    assign hit_vector    = is_reg(paddr, `IVS_OFF_VECTOR);
    assign hit_irq_stat  = is_reg(paddr, `IVS_OFF_IRQ_STAT);
    assign addr_ok = hit_en_first | hit_en_second | hit_nmi_ctl | hit_mflag |
                     hit_nflag | hit_irq_mask | hit_vector | hit_irq_stat;
    // unmapped accesses are refused: the write is dropped and a read returns zero
    assign pslverr = psel & penable & ~addr_ok;

    // request flags: one per source, the timer-2 group keeps three
    assign mset = {adc_req, lin_req, fdiv_ovf_req, timer2_req, serial_req,
                   timer1_req, ext_rise[1], timer0_req, ext_rise[0]};
    assign mclr = (wr_en && hit_mflag) ? pwdata[8:0] : 9'h000;
    assign nclr = (wr_en && hit_nflag) ? pwdata[5:0] : 6'h00;

    ivs_flags #(
        .W(9)
    ) u_mflags (
        .sys_clk  (sys_clk),
        .rstn     (rstn),
        .set_in   (mset),
        .clr_in   (mclr),
        .flag_out (mflag)
    );

    ivs_flags #(
        .W(6)
    ) u_nflags (
        .sys_clk  (sys_clk),
        .rstn     (rstn),
        .set_in   (nmi_src_req),
        .clr_in   (nclr),
        .flag_out (nflag)
    );

    // pending per vector, each gated by its own enable
    assign vec_pend[0] = mflag[0] & ext_irq0_enable;
    assign vec_pend[1] = mflag[1] & timer0_irq_enable;
    assign vec_pend[2] = mflag[2] & ext_irq1_enable;
    assign vec_pend[3] = mflag[3] & timer1_irq_enable;
    assign vec_pend[4] = mflag[4] & serial_irq_enable;
    assign vec_pend[5] = (|mflag[`IVS_F_LIN:`IVS_F_TMR2]) & timer2_group_irq_enable;
    assign vec_pend[6] = mflag[`IVS_F_ADC] & converter_irq_enable;
    assign nmi_pend = nflag & nonmaskable_control_reg_r[5:0];

    assign core_nmi_req = |nmi_pend;
    assign core_irq_req = |vec_pend;

    // vector presented to the core; nmi wins over maskable, held when idle
    always @* begin
        vector_nxt = core_vector;
        if (|nmi_pend) begin
            vector_nxt = `IVS_VEC_NMI;
        end else if (|vec_pend) begin
            vector_nxt = vec_addr(first_set(vec_pend));
        end
    end

    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            core_vector <= 16'h0000;
        end else begin
            core_vector <= vector_nxt;
        end
    end

    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            core_ack_d_r <= 1'b0;
        end else begin
            core_ack_d_r <= core_ack;
        end
    end

    assign ack_edge = core_ack & ~core_ack_d_r;
    assign stat_set = {ack_edge & core_nmi_req, ack_edge};

    // register next values; a status event in the cycle of its clear wins
    always @* begin
        en_first_nxt  = irq_enable_reg_first_r;
        en_second_nxt = irq_enable_reg_second_r;
        nmi_ctl_nxt   = nonmaskable_control_reg_r;
        irq_mask_nxt  = irq_mask_r;
        stat_nxt      = stat_set | stat_r;
        if (wr_en && hit_en_first) begin
            en_first_nxt = pwdata[7:0];
        end
        if (wr_en && hit_en_second) begin
            en_second_nxt = pwdata[7:0];
        end
        if (wr_en && hit_nmi_ctl) begin
            nmi_ctl_nxt = {2'h0, pwdata[5:0]};
        end
        if (wr_en && hit_irq_mask) begin
            irq_mask_nxt = pwdata[1:0];
        end
        if (wr_en && hit_irq_stat) begin
            stat_nxt = stat_set | (stat_r & ~pwdata[1:0]);
        end
    end

    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            irq_enable_reg_first_r    <= `IVS_EN_FIRST_RST;
            irq_enable_reg_second_r   <= `IVS_EN_SECOND_RST;
            nonmaskable_control_reg_r <= `IVS_NMICTL_RST;
            irq_mask_r                <= 2'h0;
            stat_r                    <= 2'h0;
        end else begin
            irq_enable_reg_first_r    <= en_first_nxt;
            irq_enable_reg_second_r   <= en_second_nxt;
            nonmaskable_control_reg_r <= nmi_ctl_nxt;
            irq_mask_r                <= irq_mask_nxt;
            stat_r                    <= stat_nxt;
        end
    end

    assign irq = |(stat_r & irq_mask_r);

    // read data chosen here, captured in the setup cycle so it stands in the access
    always @* begin
        case (paddr)
            `IVS_OFF_EN_FIRST:  rd_nxt = {24'h000000, irq_enable_reg_first_r};
            `IVS_OFF_EN_SECOND: rd_nxt = {24'h000000, irq_enable_reg_second_r};
            `IVS_OFF_NMICTL:    rd_nxt = {24'h000000, nonmaskable_control_reg_r};
            `IVS_OFF_MASK_FLAG: rd_nxt = {23'h000000, mflag};
            `IVS_OFF_NMI_FLAG:  rd_nxt = {26'h0000000, nflag};
            `IVS_OFF_IRQ_MASK:  rd_nxt = {30'h0000000, irq_mask_r};
            `IVS_OFF_VECTOR:    rd_nxt = {16'h0000, core_vector};
            `IVS_OFF_IRQ_STAT:  rd_nxt = {30'h0000000, stat_r};
            default:            rd_nxt = 32'h00000000;
        endcase
    end

    assign rd_setup = psel & ~penable & ~pwrite;

    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            prdata <= 32'h00000000;
        end else if (rd_setup) begin
            prdata <= rd_nxt;
        end
    end
endmodule
`default_nettype wire

// File: dv/ivs_ctrl_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module ivs_ctrl_assertions (
    input wire logic        sys_clk,
    input wire logic        rstn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        core_irq_req,
    input wire logic        core_nmi_req,
    input wire logic [15:0] core_vector,
    input wire logic        core_ack,
    input wire logic        irq
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);
    wire acc = psel && penable;
    wire wr  = acc && pwrite;

    a_pready_high: assert property (pready)
        else $error("pready low");
    a_bad_addr_err: assert property (acc && (paddr > 12'h01C || paddr[1:0] != 2'h0) |-> pslverr)
        else $error("no error on unmapped access");
    a_good_addr_ok: assert property (acc && paddr <= 12'h01C && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("error on mapped access");
    a_err_read_zero: assert property (acc && !pwrite && pslverr |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    a_nmi_vector: assert property (core_nmi_req |=> core_vector == 16'h0073)
        else $error("nmi vector wrong");
    a_mask_vector: assert property (core_irq_req && !core_nmi_req |=>
        core_vector[2:0] == 3'h3 && core_vector <= 16'h0033)
        else $error("maskable vector out of table");
    a_vector_hold: assert property (!core_irq_req && !core_nmi_req |=>
        $stable(core_vector))
        else $error("vector moved with nothing pending");
    a_irq_cause: assert property ($rose(irq) |->
        $past(core_ack, 1) || $past(core_ack, 2) || $past(wr, 1) || $past(wr, 2))
        else $error("irq rose without cause");
    a_irq_drop_write: assert property ($fell(irq) |-> $past(wr, 1) || $past(wr, 2))
        else $error("irq fell without write");

    c_nmi: cover property (core_nmi_req);
    c_shared: cover property (core_irq_req && core_vector == 16'h002B);
    c_irq: cover property ($rose(irq));
    c_nmi_accept: cover property (core_ack && core_nmi_req);
endmodule
bind ivs_ctrl ivs_ctrl_assertions chk (.sys_clk, .rstn, .psel, .penable, .pwrite, .paddr,
    .prdata, .pready, .pslverr, .core_irq_req, .core_nmi_req, .core_vector, .core_ack, .irq);
`default_nettype wire

// File: dv/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic        sys_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, core_ack = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [8:0]  src = 0;
    logic [5:0]  nmi = 0;
    logic [15:0] core_vector;
    logic        pready, pslverr, err, core_irq_req, core_nmi_req, irq;
    int          n_fail = 0, num_checks = 0;
    ivs_ctrl uut (.sys_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .ext_irq0_pin(src[0]), .timer0_req(src[1]), .ext_irq1_pin(src[2]),
        .timer1_req(src[3]), .serial_req(src[4]), .timer2_req(src[5]), .fdiv_ovf_req(src[6]),
        .lin_req(src[7]), .adc_req(src[8]), .nmi_src_req(nmi), .core_irq_req, .core_nmi_req,
        .core_vector, .core_ack, .irq);
    initial forever #50 sys_clk = ~sys_clk;

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d errors %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic look;
        @(negedge sys_clk);
    endtask
    // one apb transfer, started and released right after rising edges
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic pulse(input logic [8:0] s, input logic [5:0] n);
        @(posedge sys_clk);
        src <= s;
        nmi <= n;
        repeat (4) @(posedge sys_clk);
        src <= 0;
        nmi <= 0;
        repeat (2) @(posedge sys_clk);
        look;
    endtask

    task automatic t_regs;
        for (int a = 0; a < 8; a++) begin
            apb(0, 12'(4 * a), 0);
            chk("reset value", 32'h0, rd);
            chk("mapped rd err", 32'h0, err);
        end
        apb(0, 12'h040, 0);
        chk("unmapped rd err", 32'h1, err);
        chk("unmapped rd data", 32'h0, rd);
        apb(1, 12'h044, 32'hFFFFFFFF);
        chk("unmapped wr err", 32'h1, err);
    endtask
    // each maskable source: gated, flag visible, then enabled and vectored
    task automatic t_vec;
        int v;
        for (int s = 0; s < 9; s++) begin
            v = s < 5 ? s : (s < 8 ? 5 : 6);
            pulse(9'(1 << s), 6'h00);
            chk("irq gated", 32'h0, core_irq_req);
            apb(0, 12'h00C, 0);
            chk("source flag", 32'(1 << s), rd);
            apb(1, v == 6 ? 12'h004 : 12'h000, 32'(1 << (v % 6)));
            look;
            chk("irq req", 32'h1, core_irq_req);
            @(posedge sys_clk);
            look;
            chk("vector", 32'(16'h0003 + 16'(8 * v)), core_vector);
            apb(1, 12'h00C, 32'(1 << s));
            apb(1, v == 6 ? 12'h004 : 12'h000, 0);
            look;
            chk("irq cleared", 32'h0, core_irq_req);
        end
    endtask
    task automatic t_nmi;
        for (int i = 0; i < 6; i++) begin
            pulse(9'h000, 6'(1 << i));
            chk("nmi gated", 32'h0, core_nmi_req);
            apb(0, 12'h010, 0);
            chk("nmi flag", 32'(1 << i), rd);
            apb(1, 12'h008, 32'(1 << i));
            look;
            chk("nmi req", 32'h1, core_nmi_req);
            @(posedge sys_clk);
            look;
            chk("nmi vector", 32'h0073, core_vector);
            apb(1, 12'h010, 32'(1 << i));
            apb(1, 12'h008, 0);
        end
    endtask
    task automatic t_irq;
        pulse(9'h002, 6'h00);
        apb(1, 12'h000, 32'h2);
        apb(1, 12'h014, 32'h1);
        @(posedge sys_clk);
        core_ack <= 1;
        @(posedge sys_clk);
        core_ack <= 0;
        repeat (2) @(posedge sys_clk);
        look;
        chk("irq set", 32'h1, irq);
        apb(0, 12'h01C, 0);
        chk("accept seen", 32'h1, rd);
        apb(1, 12'h014, 0);
        look;
        chk("irq masked", 32'h0, irq);
        apb(1, 12'h014, 32'h1);
        apb(1, 12'h01C, 32'h1);
        look;
        chk("irq cleared", 32'h0, irq);
    endtask
    // two maskable vectors pending: lowest index first; an nmi then overrides
    task automatic t_prio;
        pulse(9'h014, 6'h01);
        apb(1, 12'h000, 32'h14);
        @(posedge sys_clk);
        look;
        chk("lowest first", 32'h0013, core_vector);
        apb(1, 12'h008, 32'h1);
        @(posedge sys_clk);
        look;
        chk("nmi first", 32'h0073, core_vector);
        @(posedge sys_clk);
        core_ack <= 1;
        @(posedge sys_clk);
        core_ack <= 0;
        apb(0, 12'h01C, 0);
        chk("nmi accept seen", 32'h3, rd);
    endtask

    initial begin
        repeat (2) @(posedge sys_clk);
        rstn <= 1;
        t_regs;
        t_vec;
        t_nmi;
        t_irq;
        t_prio;
        finish_test;
    end
    initial begin
        #2000000;
        n_fail++;
        finish_test;
    end
endmodule
`default_nettype wire
